// File: src/iakb_pkg.sv
// constants, field map and carrier types for the ingress acl key builder
// assumes one core clock; header fields arrive already parsed
package iakb_pkg;

    localparam int unsigned NUM_FIELDS  = 34;
    localparam int unsigned KEY_W       = 560;
    localparam int unsigned MAX_SEL     = 22;
    localparam int unsigned FIELD_W_MAX = 128;
    localparam int unsigned RULE_PTR_W  = 2;
    localparam int unsigned NUM_RULES   = 4;
    localparam int unsigned DESC_W      = 7;
    localparam int unsigned PL_ENTRIES  = 128;
    localparam int unsigned CNT_W       = 5;

    // field index in the choice mask
    localparam int unsigned F_TCP = 0, F_DMAC = 1, F_SMAC = 2, F_OVID = 3, F_HASV = 4;
    localparam int unsigned F_OTT = 5, F_ITT = 6, F_OPCP = 7, F_ODEI = 8, F_IVID = 9;
    localparam int unsigned F_IPCP = 10, F_IDEI = 11, F_V4SA = 12, F_V4DA = 13;
    localparam int unsigned F_V6SA = 14, F_V6DA = 15, F_MPLS = 16, F_TOS = 17, F_TTL = 18;
    localparam int unsigned F_SPI = 19, F_SEQ = 20, F_MKEY = 21, F_MCTL = 22, F_SP = 23;
    localparam int unsigned F_DP = 24, F_FLOW = 25, F_L4P = 26, F_ETYPE = 27, F_L4T = 28;
    localparam int unsigned F_L3T = 29, F_SRCP = 30, F_FCRY = 31, F_SAP = 32, F_RPTR = 33;

    localparam int unsigned FIELD_W [NUM_FIELDS] = '{
        9, 48, 48, 12, 1, 1, 1, 3, 1, 12, 3, 1, 32, 32, 128, 128, 20, 8, 8,
        32, 32, 64, 8, 16, 16, 20, 8, 16, 3, 2, 4, 1, 6, 2};

    localparam logic [1:0] L3_IPV4  = 2'h0;
    localparam logic [1:0] L3_IPV6  = 2'h1;
    localparam logic [1:0] L3_MPLS  = 2'h2;
    localparam logic [1:0] L3_OTHER = 2'h3;

    localparam logic [2:0] L4_NONE   = 3'h0;
    localparam logic [2:0] L4_IP     = 3'h1;
    localparam logic [2:0] L4_UDP    = 3'h2;
    localparam logic [2:0] L4_TCP    = 3'h3;
    localparam logic [2:0] L4_IGMP   = 3'h4;
    localparam logic [2:0] L4_ICMP   = 3'h5;
    localparam logic [2:0] L4_ICMPV6 = 3'h6;
    localparam logic [2:0] L4_MLD    = 3'h7;

    localparam logic [7:0] PROTO_ICMP   = 8'h01;
    localparam logic [7:0] PROTO_IGMP   = 8'h02;
    localparam logic [7:0] PROTO_TCP    = 8'h06;
    localparam logic [7:0] PROTO_UDP    = 8'h11;
    localparam logic [7:0] PROTO_ICMPV6 = 8'h3A;
    localparam logic [7:0] MLD_TYPE_LO  = 8'h82;
    localparam logic [7:0] MLD_TYPE_HI  = 8'h84;

    localparam logic [15:0] MKEY_ES_SCB  = 16'h0000;
    localparam logic [15:0] MKEY_ES_NSCB = 16'h0001;
    localparam logic [63:0] MKEY_NONE    = 64'hFFFF_FFFF_FFFF_FFFF;

    typedef struct packed {
        logic [1:0]   port_prelookup_bits;
        logic [3:0]   src_port;
        logic [1:0]   vlan_cnt;
        logic         outer_svlan;
        logic [2:0]   outer_pcp;
        logic         outer_dei;
        logic [11:0]  outer_vid;
        logic         inner_svlan;
        logic [2:0]   inner_pcp;
        logic         inner_dei;
        logic [11:0]  inner_vid;
        logic [47:0]  dest_mac_field;
        logic [47:0]  src_mac_field;
        logic [15:0]  ether_type;
        logic         is_ipv4;
        logic         is_ipv6;
        logic         is_mpls;
        logic         is_fragment;
        logic [31:0]  ipv4_sa;
        logic [31:0]  ipv4_da;
        logic [127:0] ipv6_sa;
        logic [127:0] ipv6_da;
        logic [19:0]  mpls_label;
        logic [7:0]   tos;
        logic [7:0]   ttl;
        logic [7:0]   l4_proto;
        logic [7:0]   icmp_type;
        logic [19:0]  flow_label;
        logic         has_ipsec;
        logic [31:0]  ipsec_spi;
        logic [31:0]  ipsec_seq;
        logic         is_macsec;
        logic         sci_present;
        logic         end_station_bit;
        logic         single_copy_bcast_bit;
        logic [63:0]  sci;
        logic [7:0]   macsec_ctrl;
        logic [15:0]  l4_sport;
        logic [15:0]  l4_dport;
        logic [8:0]   tcp_flags;
        logic         from_crypto;
        logic         crypto_ok;
        logic [5:0]   sa_ptr;
    } iakb_hdr_s;

    typedef struct packed {
        logic [1:0] port_bits;
        logic [1:0] vlan_cnt;
        logic       l2_macsec;
        logic [1:0] l3_type;
    } iakb_desc_s;

endpackage

// File: src/iakb_prelookup.sv
// pre-lookup table and rule pointer choice for the key builder
// assumes table writes come from the same clock domain
`timescale 1ns/1ps
module iakb_prelookup (
    input  wire logic                            clk_i,
    input  wire logic                            reset_i,
    input  wire logic                            hdr_valid_i,
    input  wire iakb_pkg::iakb_hdr_s             hdr_i,
    input  wire logic [iakb_pkg::RULE_PTR_W-1:0] port_rule_ptr_i,
    input  wire logic                            pl_wr_en_i,
    input  wire iakb_pkg::iakb_desc_s            pl_wr_idx_i,
    input  wire logic                            pl_wr_valid_i,
    input  wire logic [iakb_pkg::RULE_PTR_W-1:0] pl_wr_ptr_i,
    output logic                                 hdr_valid_o,
    output iakb_pkg::iakb_hdr_s                  hdr_o,
    output iakb_pkg::iakb_desc_s                 desc_o,
    output logic [iakb_pkg::RULE_PTR_W-1:0]      rule_ptr_o,
    output logic                                 pl_hit_o
);
    import iakb_pkg::*;

    logic                  pl_vld_q [PL_ENTRIES];
    logic [RULE_PTR_W-1:0] pl_ptr_q [PL_ENTRIES];
    iakb_desc_s            desc;

    always_comb begin
        desc.port_bits = hdr_i.port_prelookup_bits;
        desc.vlan_cnt  = hdr_i.vlan_cnt;
        desc.l2_macsec = hdr_i.is_macsec;
        if (hdr_i.is_ipv4) begin
            desc.l3_type = L3_IPV4;
        end else if (hdr_i.is_ipv6) begin
            desc.l3_type = L3_IPV6;
        end else if (hdr_i.is_mpls) begin
            desc.l3_type = L3_MPLS;
        end else begin
            desc.l3_type = L3_OTHER;
        end
    end

    // table storage
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < PL_ENTRIES; i++) begin
                pl_vld_q[i] <= 1'b0;
            end
        end else if (pl_wr_en_i) begin
            pl_vld_q[pl_wr_idx_i] <= pl_wr_valid_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (pl_wr_en_i) begin
            pl_ptr_q[pl_wr_idx_i] <= pl_wr_ptr_i;
        end
    end

    // lookup and fallback to the port pointer
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            hdr_valid_o <= 1'b0;
            hdr_o       <= '0;
            desc_o      <= '0;
            rule_ptr_o  <= '0;
            pl_hit_o    <= 1'b0;
        end else begin
            hdr_valid_o <= hdr_valid_i;
            hdr_o       <= hdr_i;
            desc_o      <= desc;
            pl_hit_o    <= pl_vld_q[desc];
            rule_ptr_o  <= pl_vld_q[desc] ? pl_ptr_q[desc] : port_rule_ptr_i;
        end
    end

    AST_PL_FALLBACK: assert property (@(posedge clk_i) disable iff (reset_i)
        hdr_valid_i && !pl_vld_q[desc] |=> !pl_hit_o && rule_ptr_o == $past(port_rule_ptr_i))
        else $error("port pointer not used on pre-lookup miss");
    AST_PL_DESC: assert property (@(posedge clk_i) disable iff (reset_i)
        hdr_valid_i |=> hdr_valid_o && desc_o.port_bits == $past(hdr_i.port_prelookup_bits)
            && desc_o.vlan_cnt == $past(hdr_i.vlan_cnt))
        else $error("descriptor parts wrong");
    AST_PL_MACSEC: assert property (@(posedge clk_i) disable iff (reset_i)
        hdr_valid_i |=> desc_o.l2_macsec == $past(hdr_i.is_macsec))
        else $error("l2 protocol flag wrong");
    AST_PL_L3: assert property (@(posedge clk_i) disable iff (reset_i)
        hdr_valid_i && hdr_i.is_ipv6 && !hdr_i.is_ipv4 |=> desc_o.l3_type == L3_IPV6)
        else $error("l3 type encoding wrong for ipv6");

endmodule

// File: src/iakb_key_builder.sv
// search key builder for the third ingress acl engine
// assumes parser presents one header per hdr_valid_i pulse, key follows two cycles later
`timescale 1ns/1ps
// Summary of operation
// - miss in pre-lookup uses port pointer
// - descriptor: port bits, vlan count, l2, l3
// - l2 flag set only for macsec
// - l3 code: ipv4, ipv6, mpls, other
// - mask bits pick fields, 22 max, 560 bits
// - choice mask is 34 bits wide
// - field 0 tcp flags, tcp non-fragment only
// - macs always valid, outer vid needs tag
// - has-vlan flag always valid
// - tag type bits, valid when tag exists
// - outer pcp, dei need one tag, inner fields need two tags
// - tos for ip, ttl for ip or mpls
// - ipsec spi and seq for ip ipsec
// - macsec key chosen from sc, es, scb
// - macsec control byte after ethertype
// - l4 ports valid for ip udp/tcp
// - ethertype, flow label, l4 protocol fields
// - l4 type three bit encoding
// - l3 type always valid, port four bits
// - rule pointer field two bits
// - valid bits lowest, fields packed above
module iakb_key_builder (
    input  wire logic                            clk_i,
    input  wire logic                            reset_i,
    input  wire logic                            hdr_valid_i,
    input  wire iakb_pkg::iakb_hdr_s             hdr_i,
    input  wire logic [iakb_pkg::RULE_PTR_W-1:0] port_rule_ptr_i,
    input  wire logic                            pl_wr_en_i,
    input  wire iakb_pkg::iakb_desc_s            pl_wr_idx_i,
    input  wire logic                            pl_wr_valid_i,
    input  wire logic [iakb_pkg::RULE_PTR_W-1:0] pl_wr_ptr_i,
    input  wire logic                            rule_wr_en_i,
    input  wire logic [iakb_pkg::RULE_PTR_W-1:0] rule_wr_idx_i,
    input  wire logic [iakb_pkg::NUM_FIELDS-1:0] rule_wr_mask_i,
    output logic                                 key_valid_o,
    output logic [iakb_pkg::KEY_W-1:0]           key_o,
    output logic [iakb_pkg::RULE_PTR_W-1:0]      key_rule_ptr_o,
    output logic                                 key_pl_hit_o,
    output logic [iakb_pkg::CNT_W-1:0]           key_field_count_o,
    output logic                                 key_trunc_o
);
    import iakb_pkg::*;

    localparam logic [NUM_FIELDS-1:0] ONE_MASK  = {{(NUM_FIELDS-1){1'b0}}, 1'b1};
    localparam logic [NUM_FIELDS-1:0] EX_MASK   = (ONE_MASK << F_DMAC) | (ONE_MASK << F_OVID);
    localparam int unsigned           EX_VLD_W  = 2;
    localparam int unsigned           EX_VID_LO = EX_VLD_W;
    localparam int unsigned           EX_MAC_LO = EX_VID_LO + 12;
    localparam logic [NUM_FIELDS-1:0] HASV_MASK = ONE_MASK << F_HASV;
    localparam logic [NUM_FIELDS-1:0] OVID_MASK = ONE_MASK << F_OVID;

    logic                         s1_valid;
    iakb_hdr_s                    s1_hdr;
    iakb_desc_s                   s1_desc;
    logic [RULE_PTR_W-1:0]        s1_ptr;
    logic                         s1_hit;
    logic [NUM_FIELDS-1:0]        rule_mask_q [NUM_RULES];
    logic [NUM_FIELDS-1:0]        s1_mask;
    logic [FIELD_W_MAX-1:0]       fval [NUM_FIELDS];
    logic [NUM_FIELDS-1:0]        fvld;
    logic [NUM_FIELDS-1:0]        pass;
    logic [2:0]                   l4_type;
    logic [63:0]                  mkey;
    logic                         ip_any;
    logic                         has_tag1;
    logic                         has_tag2;
    logic [KEY_W-1:0]             key_d;
    logic [CNT_W-1:0]             cnt_d;
    logic                         trunc_d;

    iakb_prelookup u_prelookup (
        .clk_i           (clk_i),
        .reset_i         (reset_i),
        .hdr_valid_i     (hdr_valid_i),
        .hdr_i           (hdr_i),
        .port_rule_ptr_i (port_rule_ptr_i),
        .pl_wr_en_i      (pl_wr_en_i),
        .pl_wr_idx_i     (pl_wr_idx_i),
        .pl_wr_valid_i   (pl_wr_valid_i),
        .pl_wr_ptr_i     (pl_wr_ptr_i),
        .hdr_valid_o     (s1_valid),
        .hdr_o           (s1_hdr),
        .desc_o          (s1_desc),
        .rule_ptr_o      (s1_ptr),
        .pl_hit_o        (s1_hit)
    );

    // rule setup table, one choice mask per rule pointer
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < NUM_RULES; i++) begin
                rule_mask_q[i] <= '0;
            end
        end else if (rule_wr_en_i) begin
            rule_mask_q[rule_wr_idx_i] <= rule_wr_mask_i;
        end
    end

    assign s1_mask  = rule_mask_q[s1_ptr];
    assign ip_any   = (s1_desc.l3_type == L3_IPV4) || (s1_desc.l3_type == L3_IPV6);
    assign has_tag1 = (s1_desc.vlan_cnt != 2'h0);
    assign has_tag2 = (s1_desc.vlan_cnt >= 2'h2);

    // l4 type classification
    always_comb begin
        l4_type = L4_NONE;
        if (ip_any) begin
            l4_type = L4_IP;
            if (s1_hdr.l4_proto == PROTO_UDP) begin
                l4_type = L4_UDP;
            end else if (s1_hdr.l4_proto == PROTO_TCP) begin
                l4_type = L4_TCP;
            end else if (s1_hdr.l4_proto == PROTO_IGMP) begin
                l4_type = L4_IGMP;
            end else if (s1_hdr.l4_proto == PROTO_ICMP) begin
                l4_type = L4_ICMP;
            end else if (s1_hdr.l4_proto == PROTO_ICMPV6 && s1_desc.l3_type == L3_IPV6) begin
                if (s1_hdr.icmp_type >= MLD_TYPE_LO && s1_hdr.icmp_type <= MLD_TYPE_HI) begin
                    l4_type = L4_MLD;
                end else begin
                    l4_type = L4_ICMPV6;
                end
            end
        end
    end

    // macsec key selection
    always_comb begin
        if (s1_hdr.sci_present) begin
            mkey = s1_hdr.sci;
        end else if (s1_hdr.end_station_bit && s1_hdr.single_copy_bcast_bit) begin
            mkey = {s1_hdr.src_mac_field, MKEY_ES_SCB};
        end else if (s1_hdr.end_station_bit) begin
            mkey = {s1_hdr.src_mac_field, MKEY_ES_NSCB};
        end else begin
            mkey = MKEY_NONE;
        end
    end

    // field values and validity
    always_comb begin
        for (int i = 0; i < NUM_FIELDS; i++) begin
            fval[i] = '0;
        end
        fval[F_TCP]   = FIELD_W_MAX'(s1_hdr.tcp_flags);
        fval[F_DMAC]  = FIELD_W_MAX'(s1_hdr.dest_mac_field);
        fval[F_SMAC]  = FIELD_W_MAX'(s1_hdr.src_mac_field);
        fval[F_OVID]  = FIELD_W_MAX'(s1_hdr.outer_vid);
        fval[F_HASV]  = FIELD_W_MAX'(has_tag1);
        fval[F_OTT]   = FIELD_W_MAX'(s1_hdr.outer_svlan);
        fval[F_ITT]   = FIELD_W_MAX'(s1_hdr.inner_svlan);
        fval[F_OPCP]  = FIELD_W_MAX'(s1_hdr.outer_pcp);
        fval[F_ODEI]  = FIELD_W_MAX'(s1_hdr.outer_dei);
        fval[F_IVID]  = FIELD_W_MAX'(s1_hdr.inner_vid);
        fval[F_IPCP]  = FIELD_W_MAX'(s1_hdr.inner_pcp);
        fval[F_IDEI]  = FIELD_W_MAX'(s1_hdr.inner_dei);
        fval[F_V4SA]  = FIELD_W_MAX'(s1_hdr.ipv4_sa);
        fval[F_V4DA]  = FIELD_W_MAX'(s1_hdr.ipv4_da);
        fval[F_V6SA]  = s1_hdr.ipv6_sa;
        fval[F_V6DA]  = s1_hdr.ipv6_da;
        fval[F_MPLS]  = FIELD_W_MAX'(s1_hdr.mpls_label);
        fval[F_TOS]   = FIELD_W_MAX'(s1_hdr.tos);
        fval[F_TTL]   = FIELD_W_MAX'(s1_hdr.ttl);
        fval[F_SPI]   = FIELD_W_MAX'(s1_hdr.ipsec_spi);
        fval[F_SEQ]   = FIELD_W_MAX'(s1_hdr.ipsec_seq);
        fval[F_MKEY]  = FIELD_W_MAX'(mkey);
        fval[F_MCTL]  = FIELD_W_MAX'(s1_hdr.macsec_ctrl);
        fval[F_SP]    = FIELD_W_MAX'(s1_hdr.l4_sport);
        fval[F_DP]    = FIELD_W_MAX'(s1_hdr.l4_dport);
        fval[F_FLOW]  = FIELD_W_MAX'(s1_hdr.flow_label);
        fval[F_L4P]   = FIELD_W_MAX'(s1_hdr.l4_proto);
        fval[F_ETYPE] = FIELD_W_MAX'(s1_hdr.ether_type);
        fval[F_L4T]   = FIELD_W_MAX'(l4_type);
        fval[F_L3T]   = FIELD_W_MAX'(s1_desc.l3_type);
        fval[F_SRCP]  = FIELD_W_MAX'(s1_hdr.src_port);
        fval[F_FCRY]  = FIELD_W_MAX'(s1_hdr.from_crypto);
        fval[F_SAP]   = FIELD_W_MAX'(s1_hdr.sa_ptr);
        fval[F_RPTR]  = FIELD_W_MAX'(s1_ptr);

        fvld          = '1;
        fvld[F_TCP]   = (l4_type == L4_TCP) && !s1_hdr.is_fragment;
        fvld[F_OVID]  = has_tag1;
        fvld[F_OTT]   = has_tag1;
        fvld[F_ITT]   = has_tag2;
        fvld[F_OPCP]  = has_tag1;
        fvld[F_ODEI]  = has_tag1;
        fvld[F_IVID]  = has_tag2;
        fvld[F_IPCP]  = has_tag2;
        fvld[F_IDEI]  = has_tag2;
        fvld[F_V4SA]  = (s1_desc.l3_type == L3_IPV4);
        fvld[F_V4DA]  = (s1_desc.l3_type == L3_IPV4);
        fvld[F_V6SA]  = (s1_desc.l3_type == L3_IPV6);
        fvld[F_V6DA]  = (s1_desc.l3_type == L3_IPV6);
        fvld[F_MPLS]  = (s1_desc.l3_type == L3_MPLS);
        fvld[F_TOS]   = ip_any;
        fvld[F_TTL]   = ip_any || (s1_desc.l3_type == L3_MPLS);
        fvld[F_SPI]   = ip_any && s1_hdr.has_ipsec;
        fvld[F_SEQ]   = ip_any && s1_hdr.has_ipsec;
        fvld[F_MKEY]  = s1_hdr.is_macsec;
        fvld[F_MCTL]  = s1_hdr.is_macsec;
        fvld[F_SP]    = (l4_type == L4_UDP) || (l4_type == L4_TCP);
        fvld[F_DP]    = (l4_type == L4_UDP) || (l4_type == L4_TCP);
        fvld[F_FLOW]  = (s1_desc.l3_type == L3_IPV6);
        fvld[F_L4P]   = ip_any;
        fvld[F_SAP]   = s1_hdr.from_crypto && s1_hdr.crypto_ok;

        for (int i = 0; i < NUM_FIELDS; i++) begin
            if (!fvld[i]) begin
                fval[i] = '0;
            end
        end
    end

    // selection limited to the first fields by index
    always_comb begin
        int unsigned n;
        n = 0;
        for (int i = 0; i < NUM_FIELDS; i++) begin
            pass[i] = s1_mask[i] && (n < MAX_SEL);
            if (pass[i]) begin
                n = n + 1;
            end
        end
    end

    // packing: valid bits at the bottom, lowest index field at the top
    always_comb begin
        int unsigned nsel;
        int unsigned pos;
        int unsigned vb;
        nsel    = 0;
        pos     = 0;
        vb      = 0;
        key_d   = '0;
        trunc_d = 1'b0;
        for (int i = 0; i < NUM_FIELDS; i++) begin
            if (pass[i]) begin
                nsel = nsel + 1;
            end
        end
        pos     = nsel;
        trunc_d = (s1_mask != pass);
        for (int i = NUM_FIELDS - 1; i >= 0; i--) begin
            if (pass[i]) begin
                if (pos + FIELD_W[i] <= KEY_W) begin
                    key_d    = key_d | ({{(KEY_W - FIELD_W_MAX){1'b0}}, fval[i]} << pos);
                    key_d[vb] = fvld[i];
                    pos      = pos + FIELD_W[i];
                end else begin
                    trunc_d  = 1'b1;
                end
                vb = vb + 1;
            end
        end
        cnt_d = CNT_W'(nsel);
    end

    // output register
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            key_valid_o       <= 1'b0;
            key_o             <= '0;
            key_rule_ptr_o    <= '0;
            key_pl_hit_o      <= 1'b0;
            key_field_count_o <= '0;
            key_trunc_o       <= 1'b0;
        end else begin
            key_valid_o       <= s1_valid;
            key_o             <= s1_valid ? key_d : '0;
            key_rule_ptr_o    <= s1_ptr;
            key_pl_hit_o      <= s1_hit;
            key_field_count_o <= cnt_d;
            key_trunc_o       <= s1_valid && trunc_d;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    AST_KEY_LATENCY: assert property (
        hdr_valid_i |-> ##2 key_valid_o)
        else $error("key did not follow header by two cycles");

    AST_SEL_LIMIT: assert property (
        key_valid_o |-> key_field_count_o <= CNT_W'(MAX_SEL))
        else $error("more fields selected than allowed");

    AST_EXAMPLE_LAYOUT: assert property (
        s1_valid && s1_mask == EX_MASK && has_tag1
        |=> key_o[EX_MAC_LO +: 48] == $past(s1_hdr.dest_mac_field)
            && key_o[EX_VID_LO +: 12] == $past(s1_hdr.outer_vid)
            && key_o[EX_VLD_W-1:0] == 2'h3)
        else $error("two field key layout wrong");

    AST_HAS_VLAN: assert property (
        s1_valid && s1_mask == HASV_MASK
        |=> key_o[0] && key_o[1] == ($past(s1_desc.vlan_cnt) != 2'h0)
            && key_field_count_o == CNT_W'(1))
        else $error("has-vlan field wrong");

    AST_INVALID_ZERO: assert property (
        s1_valid && s1_mask == OVID_MASK && !has_tag1 |=> key_o == '0)
        else $error("invalid field not zeroed");

    AST_TCP_FRAG: assert property (
        s1_valid && s1_hdr.is_fragment |-> !fvld[F_TCP])
        else $error("tcp flags valid on a fragment");

    AST_ONE_TAG: assert property (
        s1_valid && s1_hdr.vlan_cnt == 2'h1 |-> fvld[F_OVID] && !fvld[F_IVID] && !fvld[F_ITT])
        else $error("vlan field validity wrong for one tag");

    AST_MPLS_TTL: assert property (
        s1_valid && s1_desc.l3_type == L3_MPLS |-> fvld[F_TTL] && !fvld[F_TOS])
        else $error("tos or ttl validity wrong for mpls");

    AST_NO_IPSEC: assert property (
        s1_valid && !s1_hdr.has_ipsec |-> !fvld[F_SPI] && !fvld[F_SEQ])
        else $error("ipsec fields valid without ipsec header");

    AST_MACSEC_CTL: assert property (
        s1_valid |-> fvld[F_MCTL] == s1_hdr.is_macsec)
        else $error("macsec control validity wrong");

    AST_ICMP_PORTS: assert property (
        s1_valid && l4_type == L4_ICMP |-> !fvld[F_SP] && !fvld[F_DP])
        else $error("l4 ports valid for icmp");

    AST_ETYPE_FLOW: assert property (
        s1_valid |-> fvld[F_ETYPE] && fvld[F_FLOW] == (s1_desc.l3_type == L3_IPV6))
        else $error("ethertype or flow label validity wrong");

    AST_SA_PTR: assert property (
        s1_valid && !s1_hdr.crypto_ok |-> fvld[F_FCRY] && !fvld[F_SAP])
        else $error("sa pointer valid without crypto success");

endmodule

// File: bench/iakb_parser_model.sv
// upstream header parser model feeding the key builder
// assumes the bench calls send from its main sequence only
`timescale 1ns/1ps
module iakb_parser_model (
    input  wire logic                            clk_i,
    output logic                                 hdr_valid_o,
    output iakb_pkg::iakb_hdr_s                  hdr_o,
    output logic [iakb_pkg::RULE_PTR_W-1:0]      port_rule_ptr_o
);
    import iakb_pkg::*;
    initial begin
        hdr_valid_o     = 1'b0;
        hdr_o           = '0;
        port_rule_ptr_o = '0;
    end
    // one-cycle header pulse; released lines show inverted data
    task automatic send(input iakb_hdr_s h, input logic [RULE_PTR_W-1:0] p);
        @(negedge clk_i);
        hdr_valid_o     = 1'b1;
        hdr_o           = h; // sec tag bits as parsed
        port_rule_ptr_o = p;
        @(negedge clk_i);
        hdr_valid_o     = 1'b0;
        hdr_o           = ~h;
        port_rule_ptr_o = ~p;
    endtask
endmodule

// File: bench/iakb_key_builder_tb.sv
// self-checking bench for the key builder
// assumes key_valid_o rises on the edge after the one that takes a header
`timescale 1ns/1ps
module iakb_key_builder_tb;
    import iakb_pkg::*;
    logic                  clk_i, reset_i, hdr_valid_i, pl_wr_en_i, pl_wr_valid_i, rule_wr_en_i;
    logic                  key_valid, key_hit, key_trunc;
    logic [RULE_PTR_W-1:0] port_ptr, pl_wr_ptr_i, rule_wr_idx_i, key_ptr;
    logic [NUM_FIELDS-1:0] rule_wr_mask_i;
    logic [KEY_W-1:0]      key;
    logic [CNT_W-1:0]      key_cnt;
    iakb_hdr_s             hdr_i, h;
    iakb_desc_s            pl_wr_idx_i;
    int                    failures, checks_done, k;
    logic [7:0]            pr [9] = '{PROTO_TCP, PROTO_TCP, PROTO_UDP, PROTO_ICMP, PROTO_IGMP,
                                      8'h2F, PROTO_ICMPV6, PROTO_ICMPV6, PROTO_TCP};
    logic [2:0]            cd [9] = '{3'h3, 3'h3, 3'h2, 3'h5, 3'h4, 3'h1, 3'h6, 3'h7, 3'h0};
    logic [63:0]           mk;
    iakb_parser_model model (.clk_i(clk_i), .hdr_valid_o(hdr_valid_i), .hdr_o(hdr_i),
                             .port_rule_ptr_o(port_ptr));
    iakb_key_builder uut (.clk_i(clk_i), .reset_i(reset_i), .hdr_valid_i(hdr_valid_i),
        .hdr_i(hdr_i), .port_rule_ptr_i(port_ptr), .pl_wr_en_i(pl_wr_en_i),
        .pl_wr_idx_i(pl_wr_idx_i), .pl_wr_valid_i(pl_wr_valid_i), .pl_wr_ptr_i(pl_wr_ptr_i),
        .rule_wr_en_i(rule_wr_en_i), .rule_wr_idx_i(rule_wr_idx_i),
        .rule_wr_mask_i(rule_wr_mask_i), .key_valid_o(key_valid), .key_o(key),
        .key_rule_ptr_o(key_ptr), .key_pl_hit_o(key_hit), .key_field_count_o(key_cnt),
        .key_trunc_o(key_trunc));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic check(input string name, input logic [KEY_W-1:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task automatic wr_rule(input logic [1:0] idx, input logic [NUM_FIELDS-1:0] m);
        @(negedge clk_i);
        rule_wr_en_i   = 1'b1;
        rule_wr_idx_i  = idx;
        rule_wr_mask_i = m;
        @(negedge clk_i);
        rule_wr_en_i   = 1'b0;
    endtask
    task automatic wr_pl(input iakb_desc_s d, input logic [1:0] p);
        @(negedge clk_i);
        pl_wr_en_i    = 1'b1;
        pl_wr_idx_i   = d;
        pl_wr_valid_i = 1'b1;
        pl_wr_ptr_i   = p;
        @(negedge clk_i);
        pl_wr_en_i    = 1'b0;
    endtask
    // send one header, wait for its key and check pointer and hit flag
    task automatic run(input iakb_hdr_s hd, input logic [1:0] p, xp, input logic xh);
        int n;
        model.send(hd, p);
        for (n = 0; n < 6 && key_valid !== 1'b1; n++) begin
            @(posedge clk_i);
            #1;
        end
        if (key_valid !== 1'b1) begin
            failures++;
            end_of_test();
        end
        check("latency", n, 1);
        check("rule_ptr", key_ptr, xp);
        check("pl_hit", key_hit, xh);
    endtask
    initial begin
        {reset_i, pl_wr_en_i, rule_wr_en_i} = 3'b100;
        {pl_wr_valid_i, pl_wr_ptr_i, rule_wr_idx_i, rule_wr_mask_i, pl_wr_idx_i} = '0;
        repeat (16) @(posedge clk_i);
        @(negedge clk_i) reset_i = 1'b0;
        wr_rule(2'h1, 34'h0_0000_000A);
        h = '0;
        h.dest_mac_field = 48'h0123_4567_89AB;
        h.outer_vid = 12'h5A5;
        h.vlan_cnt = 2'h1;
        run(h, 2'h1, 2'h1, 1'b0);
        check("key_da_vid", key, KEY_W'({h.dest_mac_field, h.outer_vid, 2'b11}));
        check("count", key_cnt, 2);
        h.vlan_cnt = 2'h0;
        run(h, 2'h1, 2'h1, 1'b0);
        check("key_novlan", key, KEY_W'({h.dest_mac_field, 12'h0, 2'b10}));
        wr_rule(2'h1, 34'h1 << F_OVID);
        run(h, 2'h1, 2'h1, 1'b0);
        check("key_novid", key, '0);
        wr_rule(2'h1, 34'h1 << F_HASV);
        h.vlan_cnt = 2'h2;
        run(h, 2'h1, 2'h1, 1'b0);
        check("has_vlan", key, 3);
        $display("test layout done");
        wr_rule(2'h2, 34'h1 << F_L3T);
        for (k = 0; k < 4; k++) begin
            wr_pl('{2'h0, 2'h0, 1'b0, 2'(k)}, 2'h2);
            h = '0;
            {h.is_ipv4, h.is_ipv6, h.is_mpls} = 3'b100 >> k;
            run(h, 2'h3, 2'h2, 1'b1);
            check("l3_type", key, KEY_W'({2'(k), 1'b1}));
        end
        $display("test prelookup done");
        wr_rule(2'h3, (34'h1 << F_L4T) | 34'h1);
        for (k = 0; k < 9; k++) begin
            h = '0;
            h.port_prelookup_bits = 2'h1;
            h.tcp_flags = 9'h1A5;
            h.is_fragment = (k == 1);
            h.is_ipv4 = (k < 6);
            h.is_ipv6 = (k == 6 || k == 7);
            h.l4_proto = pr[k];
            h.icmp_type = (k == 7) ? MLD_TYPE_LO : 8'h80;
            run(h, 2'h3, 2'h3, 1'b0);
            mk = (k == 0) ? 64'h1A5 : 64'h0;
            check("l4_tcp", key, KEY_W'({mk[8:0], cd[k], k == 0, 1'b1}));
        end
        $display("test l4 done");
        wr_rule(2'h0, 34'h1 << F_MKEY);
        wr_pl('{2'h0, 2'h0, 1'b1, L3_OTHER}, 2'h0);
        for (k = 0; k < 4; k++) begin
            h = '0;
            h.is_macsec = 1'b1;
            h.sci = 64'h1122_3344_5566_7788;
            h.src_mac_field = 48'hA1B2_C3D4_E5F6;
            h.sci_present = (k == 0);
            h.end_station_bit = (k == 1 || k == 2);
            h.single_copy_bcast_bit = (k == 1);
            mk = (k == 0) ? h.sci : (k == 1) ? {h.src_mac_field, MKEY_ES_SCB} :
                 (k == 2) ? {h.src_mac_field, MKEY_ES_NSCB} : MKEY_NONE;
            run(h, 2'h3, 2'h0, 1'b1);
            check("macsec_key", key, KEY_W'({mk, 1'b1}));
        end
        $display("test macsec done");
        wr_rule(2'h1, 34'h0_007F_FFFF);
        h.port_prelookup_bits = 2'h1;
        run(h, 2'h1, 2'h1, 1'b0);
        check("count_max", key_cnt, MAX_SEL);
        check("trunc", key_trunc, 1'b1);
        $display("test limit done");
        end_of_test();
    end
endmodule
